// ==== pec_pkg.sv ====
// Shared constants and types for the position error counter with gear.
// What this block does
// - While error_clear_n is low the position error counter is held at zero.
// - While error_clear_n is low the position loop enable is dropped.
// - With servo off, reference pulses keep accumulating unless clear mode drops them.
// - Clear mode: clear on servo off; never clear; clear on off or overtravel unless zero clamp is set.
// - Gear numerator accepts 1 to 65535, resets to 1, applies after restart.
// - Gear denominator accepts 1 to 65535, resets to 1, applies after restart.
// - Each reference pulse is scaled by numerator over denominator into counts.
// - One received reference pulse is one reference unit of commanded position.
// - Encoder feedback is 32768 lines times four, counted on every edge.
// - Pulse form selects sign plus pulse, CW and CCW, or quadrature x1/x2/x4.
package pec_pkg;

  // Bus and datapath widths.
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int GEAR_W = 16;
  localparam int ERR_W  = 48;
  localparam int POS_W  = 17;
  localparam int PF_W   = 3;
  localparam int CM_W   = 2;

  // Register byte offsets.
  localparam logic [ADDR_W-1:0] OFS_GEAR_NUM = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_GEAR_DEN = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_PULSE_CFG = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_CTRL     = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_ERR_LO   = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_ERR_HI   = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_STATUS   = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_MPOS     = 8'h1C;

  // Field positions.
  localparam int CFG_PF_LSB   = 0;
  localparam int CFG_CM_LSB   = 4;
  localparam int CTRL_RESTART = 0;
  localparam int ST_LOOP      = 0;
  localparam int ST_CLEAR     = 1;
  localparam int ST_PENDING   = 2;
  localparam int ST_RATIO_BAD = 3;

  // Reset values and gear limits.
  localparam logic [GEAR_W-1:0] GEAR_RESET = 16'h0001;
  localparam logic [GEAR_W-1:0] GEAR_ZERO  = 16'h0000;
  localparam logic [DATA_W-1:0] DATA_ZERO  = 32'h0000_0000;
  localparam int unsigned RATIO_SCALE = 100;

  // Pulse form codes.
  localparam logic [PF_W-1:0] PF_SIGN_PULSE = 3'h0;
  localparam logic [PF_W-1:0] PF_CW_CCW     = 3'h1;
  localparam logic [PF_W-1:0] PF_QUAD_X1    = 3'h2;
  localparam logic [PF_W-1:0] PF_QUAD_X2    = 3'h3;
  localparam logic [PF_W-1:0] PF_QUAD_X4    = 3'h4;

  // Clear mode codes.
  localparam logic [CM_W-1:0] CM_SOFF  = 2'h0;
  localparam logic [CM_W-1:0] CM_NEVER = 2'h1;
  localparam logic [CM_W-1:0] CM_BOTH  = 2'h2;
  localparam logic [CM_W-1:0] CM_BAD   = 2'h3;

  // Encoder resolution: lines times quadrature edges per revolution.
  localparam int unsigned ENC_LINES = 32768;
  localparam int unsigned ENC_MULT  = 4;
  localparam logic [POS_W-1:0] POS_LAST =
    POS_W'(ENC_LINES * ENC_MULT - 1);
  localparam logic [POS_W-1:0] POS_ZERO = 17'h0_0000;

  // Edge multiplication of a quadrature decoder.
  typedef enum logic [1:0] {
    PEC_X1,
    PEC_X2,
    PEC_X4
  } pec_mult_e;

endpackage

// ==== pec_quad_dec.sv ====
// Two-phase quadrature decoder with x1, x2 or x4 edge multiplication.
`timescale 1ns/1ps
module pec_quad_dec (
  input  wire logic              mclk,   // System clock.
  input  wire logic              rst_b,  // Async reset, active low.
  input  wire logic              a_in,   // Phase A level.
  input  wire logic              b_in,   // Phase B level.
  input  wire pec_pkg::pec_mult_e mult,  // Edge multiplication.
  output logic                   step,   // One-cycle count pulse.
  output logic                   fwd     // Direction of that count.
);
  import pec_pkg::*;

  typedef struct packed {
    logic pa;
    logic pb;
    logic step;
    logic fwd;
  } pec_qd_s;

  pec_qd_s q;
  pec_qd_s next_q;
  logic    ea;
  logic    eb;

  // A leading B counts forward; a double edge is noise and is dropped.
  always_comb begin
    next_q = q;
    next_q.pa = a_in;
    next_q.pb = b_in;
    ea = a_in ^ q.pa;
    eb = b_in ^ q.pb;
    next_q.step = 1'b0;
    next_q.fwd = q.fwd;
    unique case (mult)
      PEC_X1: begin
        next_q.step = ea & a_in & ~eb;
        next_q.fwd = ~b_in;
      end
      PEC_X2: begin
        next_q.step = ea & ~eb;
        next_q.fwd = a_in ^ b_in;
      end
      PEC_X4: begin
        next_q.step = ea ^ eb;
        next_q.fwd = ea ? (a_in ^ b_in) : ~(a_in ^ b_in);
      end
    endcase
  end

  // State register.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign step = q.step;
  assign fwd  = q.fwd;
endmodule

// ==== pec_error_counter.sv ====
// Electronic gear and position error counter of the position loop.
`timescale 1ns/1ps
module pec_error_counter (
  input  wire logic                      mclk,     // System clock.
  input  wire logic                      rst_b,    // Async reset, low.
  input  wire logic                      puls_in,  // Reference pulse pin.
  input  wire logic                      sign_in,  // Reference sign pin.
  input  wire logic                      enc_a,    // Encoder phase A.
  input  wire logic                      enc_b,    // Encoder phase B.
  input  wire logic                      error_clear_n, // Clear, low.
  input  wire logic                      servo_on, // Servo is on.
  input  wire logic                      overtravel, // Overtravel.
  input  wire logic                      zero_clamp, // Zero clamp.
  input  wire logic [pec_pkg::ADDR_W-1:0] addr,    // Register address.
  input  wire logic [pec_pkg::DATA_W-1:0] wr_data, // Write data.
  input  wire logic                      wr_en,    // Write strobe.
  input  wire logic                      rd_en,    // Read strobe.
  output logic      [pec_pkg::DATA_W-1:0] rd_data, // Read data.
  output logic signed [pec_pkg::ERR_W-1:0] pos_error, // Scaled error.
  output logic                           loop_enable // Loop may run.
);
  import pec_pkg::*;

  // The whole core state lives in one packed struct. Pending gear values
  // are what software last wrote; active values are what the counter
  // uses. The two differ until a restart is asked for, so a gear change
  // never lands in the middle of a move and corrupts the error.
  // The error is signed and wide enough that a long run of reference
  // pulses at the largest gear cannot wrap it before software reacts.
  typedef struct packed {
    logic [GEAR_W-1:0]       num_pend;
    logic [GEAR_W-1:0]       den_pend;
    logic [GEAR_W-1:0]       num_act;
    logic [GEAR_W-1:0]       den_act;
    logic [PF_W-1:0]         pform;
    logic [CM_W-1:0]         cmode;
    logic                    puls_q;
    logic                    sign_q;
    logic signed [ERR_W-1:0] err;
    logic [POS_W-1:0]        mpos;
    logic                    loop_en;
    logic                    clr_seen;
    logic [DATA_W-1:0]       rdata;
  } pec_core_s;

  // Combinational helpers: decoded steps, gear increments and the
  // clear that applies in this cycle.
  pec_core_s               q;
  pec_core_s               next_q;
  pec_mult_e               ref_mult;
  logic                    qd_step;
  logic                    qd_fwd;
  logic                    fb_step;
  logic                    fb_fwd;
  logic                    rise_p;
  logic                    rise_s;
  logic                    ref_step;
  logic                    ref_fwd;
  logic                    auto_clr;
  logic                    restart;
  logic                    clr;
  logic                    ratio_bad;
  logic signed [ERR_W-1:0] d_ref;
  logic signed [ERR_W-1:0] d_fb;
  logic [GEAR_W-1:0]       wr_gear;
  logic [PF_W-1:0]         wr_pf;
  logic [CM_W-1:0]         wr_cm;
  logic [DATA_W-1:0]       status;

  // Quadrature multiplication follows the selected pulse form.
  // Sign and pulse forms leave the decoder at x1; its step is unused.
  always_comb begin
    unique case (q.pform)
      PF_QUAD_X2: ref_mult = PEC_X2;
      PF_QUAD_X4: ref_mult = PEC_X4;
      default:    ref_mult = PEC_X1;
    endcase
  end

  // Reference quadrature: A (sign) leading B (pulse) is forward.
  // The decoder runs all the time, so switching to a quadrature form
  // needs no warm-up once both lines are idle.
  pec_quad_dec u_ref_dec (
    .mclk  (mclk),
    .rst_b (rst_b),
    .a_in  (sign_in),
    .b_in  (puls_in),
    .mult  (ref_mult),
    .step  (qd_step),
    .fwd   (qd_fwd)
  );

  // Encoder feedback always counts every edge of both phases.
  // Four edges per line give the full resolution of one revolution.
  pec_quad_dec u_enc_dec (
    .mclk  (mclk),
    .rst_b (rst_b),
    .a_in  (enc_a),
    .b_in  (enc_b),
    .mult  (PEC_X4),
    .step  (fb_step),
    .fwd   (fb_fwd)
  );

  // Reference pulse decode into one step per reference unit, or two at quadrature x2 and four at x4.
  // Edges are found against the level sampled one cycle earlier, so
  // an input that is already high when reset ends would count once.
  // The host keeps both lines low while idle to avoid that.
  always_comb begin
    rise_p = puls_in & ~q.puls_q;
    rise_s = sign_in & ~q.sign_q;
    ref_step = 1'b0;
    ref_fwd = 1'b1;
    unique case (q.pform)
      PF_SIGN_PULSE: begin
        ref_step = rise_p;
        ref_fwd = sign_in;
      end
      PF_CW_CCW: begin
        // Pulses on both lines together cancel out.
        // The host must not use that as a way to send two pulses.
        ref_step = rise_p ^ rise_s;
        ref_fwd = rise_p;
      end
      PF_QUAD_X1, PF_QUAD_X2, PF_QUAD_X4: begin
        ref_step = qd_step;
        ref_fwd = qd_fwd;
      end
      default: begin
        ref_step = 1'b0;
        ref_fwd = 1'b1;
      end
    endcase
  end

  // Automatic clear by mode; servo off alone keeps the error in
  // the never mode, so pulses taken while off are still counted.
  // Mode three is refused at the register, so the default arm only
  // covers a value that cannot be stored.
  always_comb begin
    unique case (q.cmode)
      CM_SOFF:  auto_clr = ~servo_on;
      CM_NEVER: auto_clr = 1'b0;
      CM_BOTH:  auto_clr = (~servo_on | overtravel) & ~zero_clamp;
      default:  auto_clr = 1'b0;
    endcase
  end

  // The error is kept in units of one over the denominator of a
  // count, so the gear needs no divider and never loses a remainder.
  // The trade is that software divides by the denominator to read
  // whole counts.
  // Forward reference adds and forward feedback subtracts, so a motor
  // that follows the command leaves the error at zero.
  always_comb begin
    d_ref = '0;
    d_fb = '0;
    if (ref_step) begin
      d_ref = ref_fwd ? signed'(ERR_W'(q.num_act))
                      : -signed'(ERR_W'(q.num_act));
    end
    if (fb_step) begin
      d_fb = fb_fwd ? signed'(ERR_W'(q.den_act))
                    : -signed'(ERR_W'(q.den_act));
    end
  end

  // Out of range ratio is only flagged; software must keep it legal.
  // Both sides are widened so the largest gear times the scale factor
  // still fits; a narrower product would wrap silently.
  assign ratio_bad =
    (24'(q.num_act) * 24'(RATIO_SCALE) < 24'(q.den_act)) ||
    (24'(q.num_act) > 24'(q.den_act) * 24'(RATIO_SCALE));

  // Write decode.
  // A restart both loads the pending gear and drops the error, since
  // an error counted at the old ratio means nothing at the new one.
  assign wr_gear = wr_data[GEAR_W-1:0];
  assign wr_pf   = wr_data[CFG_PF_LSB +: PF_W];
  assign wr_cm   = wr_data[CFG_CM_LSB +: CM_W];
  assign restart = wr_en && (addr == OFS_CTRL) &&
                   wr_data[CTRL_RESTART];
  assign clr     = ~error_clear_n | auto_clr | restart;

  // Status word seen by software.
  // Pending tells software that a restart is still needed for a gear
  // write to take effect.
  always_comb begin
    status = DATA_ZERO;
    status[ST_LOOP] = q.loop_en;
    status[ST_CLEAR] = q.clr_seen;
    status[ST_PENDING] = (q.num_pend != q.num_act) ||
                         (q.den_pend != q.den_act);
    status[ST_RATIO_BAD] = ratio_bad;
  end

  // Next state of the whole core.
  always_comb begin
    next_q = q;
    next_q.puls_q = puls_in;
    next_q.sign_q = sign_in;
    // Error accumulation; a clear always wins over a pulse.
    if (clr) begin
      next_q.err = '0;
    end else begin
      next_q.err = q.err + d_ref - d_fb;
    end
    next_q.clr_seen = clr;
    // Loop enable is registered, so it follows the clear input and the
    // servo state one cycle late, like every other output.
    // Correction runs only with servo on and clear released.
    next_q.loop_en = error_clear_n & servo_on;
    // Motor position within one revolution.
    // It wraps at one revolution in both directions and is never
    // cleared by the error clear, since it tracks the shaft, not the
    // command.
    if (fb_step) begin
      if (fb_fwd) begin
        next_q.mpos = (q.mpos == POS_LAST) ? POS_ZERO
                      : q.mpos + 17'h0_0001;
      end else begin
        next_q.mpos = (q.mpos == POS_ZERO) ? POS_LAST
                      : q.mpos - 17'h0_0001;
      end
    end
    // Register writes; out of range values are ignored.
    // A gear of zero would leave the ratio undefined, so it is dropped
    // and the old value kept; pulse form and clear mode apply at once.
    if (wr_en) begin
      unique case (addr)
        OFS_GEAR_NUM: begin
          if (wr_gear != GEAR_ZERO) begin
            next_q.num_pend = wr_gear;
          end
        end
        OFS_GEAR_DEN: begin
          if (wr_gear != GEAR_ZERO) begin
            next_q.den_pend = wr_gear;
          end
        end
        OFS_PULSE_CFG: begin
          if (wr_pf <= PF_QUAD_X4) begin
            next_q.pform = wr_pf;
          end
          if (wr_cm != CM_BAD) begin
            next_q.cmode = wr_cm;
          end
        end
        OFS_CTRL: begin
          if (wr_data[CTRL_RESTART]) begin
            next_q.num_act = q.num_pend;
            next_q.den_act = q.den_pend;
          end
        end
        default: begin
        end
      endcase
    end
    // Read data stands for one cycle only and is zero otherwise.
    // Holding zero between reads lets a bus that ORs several slaves
    // together share the read data lines.
    next_q.rdata = DATA_ZERO;
    if (rd_en) begin
      unique case (addr)
        OFS_GEAR_NUM:  next_q.rdata = DATA_W'(q.num_pend);
        OFS_GEAR_DEN:  next_q.rdata = DATA_W'(q.den_pend);
        OFS_PULSE_CFG: begin
          next_q.rdata[CFG_PF_LSB +: PF_W] = q.pform;
          next_q.rdata[CFG_CM_LSB +: CM_W] = q.cmode;
        end
        OFS_CTRL:      next_q.rdata = {q.den_act, q.num_act};
        OFS_ERR_LO:    next_q.rdata = q.err[DATA_W-1:0];
        OFS_ERR_HI:    next_q.rdata = DATA_W'(q.err[ERR_W-1:DATA_W]);
        OFS_STATUS:    next_q.rdata = status;
        OFS_MPOS:      next_q.rdata = DATA_W'(q.mpos);
        default:       next_q.rdata = DATA_ZERO;
      endcase
    end
  end

  // State register; gear settings come up at one to one.
  // The reset branch loads constants only, so the reset path stays a
  // plain asynchronous load.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
      q.num_pend <= GEAR_RESET;
      q.den_pend <= GEAR_RESET;
      q.num_act <= GEAR_RESET;
      q.den_act <= GEAR_RESET;
      q.pform <= PF_SIGN_PULSE;
      q.cmode <= CM_SOFF;
    end else begin
      q <= next_q;
    end
  end

  // Outputs come straight from the state register.
  // No logic sits between these flops and the pins, so the outputs
  // never glitch while the next state settles.
  assign rd_data     = q.rdata;
  assign pos_error   = q.err;
  assign loop_enable = q.loop_en;
endmodule

// ==== pec_error_counter_properties.sv ====
// Port-level checks for the position error counter with gear.
`timescale 1ns/1ps
module pec_checker (
  input wire logic                             mclk,          // Clock.
  input wire logic                             rst_b,         // Reset.
  input wire logic                             puls_in,       // Pulse.
  input wire logic                             sign_in,       // Sign.
  input wire logic                             enc_a,         // Phase A.
  input wire logic                             enc_b,         // Phase B.
  input wire logic                             error_clear_n, // Clear.
  input wire logic                             servo_on,      // Servo.
  input wire logic                             wr_en,         // Write.
  input wire logic                             rd_en,         // Read.
  input wire logic [pec_pkg::DATA_W-1:0]       rd_data,       // Data.
  input wire logic signed [pec_pkg::ERR_W-1:0] pos_error,     // Error.
  input wire logic                             loop_enable    // Loop.
);
  import pec_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // No line that feeds the counter moved in this cycle.
  sequence s_quiet;
    $stable(puls_in) && $stable(sign_in) && $stable(enc_a) && $stable(enc_b);
  endsequence
  // A clear inside a quiet stretch, so no late increment may follow it.
  sequence s_clr_quiet;
    s_quiet [*4] ##0 !$past(error_clear_n, 2);
  endsequence
  property p_clr_zero; !error_clear_n |=> pos_error == '0; endproperty
  a_clr_zero: assert property (p_clr_zero) else $error("clear leak");
  property p_clr_loop; !error_clear_n |=> !loop_enable; endproperty
  a_clr_loop: assert property (p_clr_loop) else $error("loop on");
  property p_loop_on; error_clear_n && servo_on |=> loop_enable; endproperty
  a_loop_on: assert property (p_loop_on) else $error("loop off");
  property p_soff_loop; !servo_on |=> !loop_enable; endproperty
  a_soff_loop: assert property (p_soff_loop) else $error("loop on");
  property p_rd_idle; !rd_en |=> rd_data == DATA_ZERO; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("stale read data");
  property p_wr_idle; wr_en |=> rd_data == DATA_ZERO; endproperty
  a_wr_idle: assert property (p_wr_idle) else $error("data on write");
  property p_rel_zero; s_clr_quiet |=> pos_error == '0; endproperty
  a_rel_zero: assert property (p_rel_zero) else $error("late step");
  property p_clr_run;
    !error_clear_n [*3] |-> pos_error == '0 && !loop_enable;
  endproperty
  a_clr_run: assert property (p_clr_run) else $error("clear run");
endmodule

bind pec_error_counter pec_checker chk (.mclk(mclk), .rst_b(rst_b),
  .puls_in(puls_in), .sign_in(sign_in), .enc_a(enc_a), .enc_b(enc_b),
  .error_clear_n(error_clear_n), .servo_on(servo_on), .wr_en(wr_en),
  .rd_en(rd_en), .rd_data(rd_data), .pos_error(pos_error),
  .loop_enable(loop_enable));

// ==== pec_host_model.sv ====
// Host controller model that sends reference pulse trains.
`timescale 1ns/1ps
module pec_host_model (
  input  wire logic mclk,    // Clock.
  output logic      puls_in, // Pulse, CW or phase B.
  output logic      sign_in  // Sign, CCW or phase A.
);
  // Both lines idle low.
  initial begin
    puls_in = 1'b0;
    sign_in = 1'b0;
  end
  // Levels stand two cycles, so no phase ever moves twice in a row.
  task automatic step(input logic s, input logic p);
    repeat (2) @(posedge mclk);
    sign_in <= s;
    puls_in <= p;
  endtask
  // Sends n reference units in form f; the gear is set by the bench.
  task automatic send(input int f, input int n, input bit d);
    for (int i = 0; i < n; i++) begin
      if (f == 0) begin
        step(d, 1'b0);
        step(d, 1'b1);
      end else if (f == 1) begin
        step(!d, d);
      end else begin
        step(d, !d);
        step(1'b1, 1'b1);
        step(!d, d);
      end
      step(f == 0 ? d : 1'b0, 1'b0);
    end
    repeat (2) @(posedge mclk);
  endtask
endmodule

// ==== tb_position_error_counter_egear.sv ====
// Self-checking bench for the position error counter with gear.
`timescale 1ns/1ps
module tb_position_error_counter_egear;
  import pec_pkg::*;
  localparam int REV = int'(POS_LAST) + 1;
  logic                    mclk, rst_b, puls_in, sign_in, enc_a, enc_b;
  logic                    error_clear_n, servo_on, overtravel, zero_clamp;
  logic                    wr_en, rd_en, loop_enable;
  logic [ADDR_W-1:0]       addr;
  logic [DATA_W-1:0]       wr_data, rd_data;
  logic signed [ERR_W-1:0] pos_error;
  logic [31:0]             seed;
  longint                  ex;
  int                      errors, cmp_count, num, den, mp, m;
  pec_error_counter dut (.mclk(mclk), .rst_b(rst_b), .puls_in(puls_in),
    .sign_in(sign_in), .enc_a(enc_a), .enc_b(enc_b),
    .error_clear_n(error_clear_n), .servo_on(servo_on),
    .overtravel(overtravel), .zero_clamp(zero_clamp), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .pos_error(pos_error), .loop_enable(loop_enable));
  pec_host_model host (.mclk(mclk), .puls_in(puls_in), .sign_in(sign_in));
  // Free-running 20 MHz clock.
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // Fixed-seed xorshift keeps every run the same.
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Four-state compare, so an unknown never passes.
  task automatic chk(input logic [47:0] g, input logic [47:0] e);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %0t got %h want %h", $time, g, e);
    end
  endtask
  // One-cycle write strobe.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge mclk);
    wr_en <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe.
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge mclk);
    rd_en <= 1'b0;
    #1 chk({16'h0, rd_data}, {16'h0, e});
  endtask
  // Quadrature needs two cycles; four leave margin.
  task automatic ce();
    repeat (4) @(posedge mclk);
    #1 chk(pos_error, ERR_W'(ex));
  endtask
  // Encoder turns n whole cycles; forward means phase A leads.
  task automatic enc(input int n, input bit f);
    logic [7:0] q;
    q = f ? 8'hB4 : 8'h78;
    for (int i = 0; i < 4 * n; i++) begin
      @(posedge mclk);
      {enc_a, enc_b} <= q[7 - 2 * (i % 4) -: 2];
    end
    ex -= (f ? 4 : -4) * n * den;
    mp = (mp + (f ? 4 : -4) * n + REV) % REV;
  endtask
  // Reference units scaled by the multiplier of the form, then the gear.
  task automatic rf(input int f, input int n, input bit d);
    host.send(f, n, d);
    ex += (d ? n : -n) * (f == 4 ? 4 : f == 3 ? 2 : 1) * num;
  endtask
  // The single place where the run ends.
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // The whole run needs under a thousand cycles.
  initial begin
    repeat (20000) @(posedge mclk);
    errors++;
    $display("CHECK FAILED %0t watchdog", $time);
    report_and_stop();
  end
  // Main sequence; every input has a value at time zero.
  initial begin
    {seed, ex, errors, cmp_count, mp} = {32'h507D, 64'h0, 96'h0};
    {rst_b, enc_a, enc_b, overtravel, zero_clamp, wr_en, rd_en} = '0;
    {error_clear_n, servo_on, addr, wr_data, num, den} = {2'b11, 40'h0, 64'h0};
    num = 1;
    den = 1;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    rdc(OFS_GEAR_NUM, 32'h1);
    rdc(OFS_GEAR_DEN, 32'h1);
    wr(OFS_GEAR_NUM, DATA_ZERO);
    rdc(OFS_GEAR_NUM, 32'h1);
    enc(1, 0);
    ce();
    rdc(OFS_MPOS, DATA_W'(mp));
    num = int'(xs() % 100) + 1;
    den = int'(xs() % 100) + 1;
    wr(OFS_GEAR_NUM, DATA_W'(num));
    wr(OFS_GEAR_DEN, DATA_W'(den));
    rdc(OFS_CTRL, 32'h0001_0001);
    wr(OFS_CTRL, 32'h1);
    ex = 0;
    rdc(OFS_CTRL, {den[15:0], num[15:0]});
    enc(3, 1);
    ce();
    rdc(OFS_MPOS, DATA_W'(mp));
    for (int f = 0; f < 5; f++) begin
      wr(OFS_PULSE_CFG, DATA_W'(f));
      rf(f, int'(xs() % 9) + 1, 1);
      rf(f, int'(xs() % 5) + 1, 0);
      ce();
    end
    wr(OFS_PULSE_CFG, 32'h5);
    rdc(OFS_PULSE_CFG, 32'h4);
    @(posedge mclk);
    error_clear_n <= 1'b0;
    host.send(4, 3, 1);
    ex = 0;
    ce();
    rdc(OFS_STATUS, 32'h2);
    @(posedge mclk);
    error_clear_n <= 1'b1;
    for (m = 0; m < 3; m++) begin
      wr(OFS_PULSE_CFG, DATA_W'(m << 4));
      rf(0, 3, 1);
      @(posedge mclk);
      servo_on <= 1'b0;
      rf(0, 2, 1);
      ex = (m == 1) ? ex : 0;
      ce();
      @(posedge mclk);
      servo_on <= 1'b1;
      rf(0, 1, 1);
      @(posedge mclk);
      {overtravel, zero_clamp} <= 2'b11;
      ce();
      @(posedge mclk);
      zero_clamp <= 1'b0;
      ex = (m == 2) ? 0 : ex;
      ce();
      @(posedge mclk);
      overtravel <= 1'b0;
    end
    report_and_stop();
  end
endmodule
